// ---- rtl/lip_top.sv ----
// Pin-function logic: LED/interrupt pin, ports A to C, pull-ups and keyboard flags
//
// How it works
// - Select bit 0 gives LED, 1 gives interrupt
// - Interrupt pin raises request without operating-clock wait
// - Trigger bit picks edge or edge-plus-level
// - LED bit 1 pulls pin low, 0 releases
// - Select and LED bits live at 1C
// - Operating clock is oscillator divided by two
// - Low reset pin restarts everything
// - All port lines are inputs after reset
// - PA1 tone, PA2 capture, PA3 compare shared
// - Port B pull-ups enabled per line
// - PB0 to PB3 raise separately enabled key flags
`timescale 1ns/100ps
`include "lip_map.svh"
module lip_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic reset_pin_n_i,
  input wire lip_pkg::lip_cpu_req_s cpu_req_i,
  output logic [7:0] cpu_rdata_o,
  output logic op_en_o,
  input wire logic irq_ack_i,
  output logic irq_req_o,
  input wire logic led_irq_pin_i,
  output logic led_irq_pin_o,
  output logic led_irq_pin_oe_o,
  input wire logic [6:0] pa_pin_i,
  input wire logic [7:0] pb_pin_i,
  input wire logic [7:0] pc_pin_i,
  output lip_pkg::lip_drive_s pa_drv_o,
  output lip_pkg::lip_drive_s pb_drv_o,
  output lip_pkg::lip_drive_s pc_drv_o,
  output logic [7:0] pb_pullup_o,
  output logic [3:0] kbd_flag_o,
  output logic kbd_irq_o,
  input wire logic tone_dac_en_i,
  input wire logic tone_dac_out_i,
  input wire logic timer_cap_en_i,
  output logic timer_capture_in_o,
  input wire logic timer_cmp_en_i,
  input wire logic timer_compare_out_i
);

  // ------------------------------------------------------------
  // Reset and operating-clock enable
  // ------------------------------------------------------------
  logic rst_pin_n_s; // Synchronised reset pin
  logic rst_all; // Combined reset
  logic op_cnt_r; // Divider phase
  logic op_cnt_nxt;
  logic op_en; // One pulse per operating cycle

  // Reset pin is asynchronous to the clock
  lip_sync2 #(.W(1), .RST_VAL(1'b1)) u_rst_sync (.mclk_i(mclk_i), .rst_i(rst_i), .d_i(reset_pin_n_i),
    .q_o(rst_pin_n_s));
  assign rst_all = rst_i | ~rst_pin_n_s;

  // Divider next phase
  always_comb begin
    op_cnt_nxt = (op_cnt_r == 1'(`LIP_OSC_DIV - 1)) ? 1'b0 : op_cnt_r + 1'b1;
  end

  // Divider register
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      op_cnt_r <= 1'b0;
    end else begin
      op_cnt_r <= op_cnt_nxt;
    end
  end
  assign op_en = (op_cnt_r == 1'(`LIP_OSC_DIV - 1));

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  logic wr_en; // Write taken this operating cycle
  logic [7:0] misc_r; // misc_ctrl_reg
  logic [7:0] misc_nxt;
  logic [7:0] pullup_r; // Port B pull-up enables
  logic [7:0] pullup_nxt;
  logic [3:0] kbd_en_r; // Key interrupt enables
  logic [3:0] kbd_en_nxt;
  logic ext_sel; // 1: interrupt input, 0: LED
  lip_pkg::lip_trig_e trig_mode;

  // Accesses are taken only on operating-clock cycles
  assign wr_en = op_en & cpu_req_i.wr;
  assign ext_sel = misc_r[`LIP_MISC_EXT_SEL];
  assign trig_mode = lip_pkg::lip_trig_e'(misc_r[`LIP_MISC_TRIG]);

  // Next control register values
  always_comb begin
    misc_nxt = misc_r;
    pullup_nxt = pullup_r;
    kbd_en_nxt = kbd_en_r;
    if (wr_en) begin
      unique case (cpu_req_i.addr)
        `LIP_ADDR_MISC: misc_nxt = cpu_req_i.wdata & `LIP_MISC_WMASK;
        `LIP_ADDR_PULLUP: pullup_nxt = cpu_req_i.wdata;
        `LIP_ADDR_KBD_EN: kbd_en_nxt = cpu_req_i.wdata[3:0];
        default: misc_nxt = misc_r; // Other offsets leave these alone
      endcase
    end
  end

  // Control registers
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      misc_r <= `LIP_MISC_RST;
      pullup_r <= `LIP_PULLUP_RST;
      kbd_en_r <= `LIP_KBD_RST;
    end else begin
      misc_r <= misc_nxt;
      pullup_r <= pullup_nxt;
      kbd_en_r <= kbd_en_nxt;
    end
  end

  // ------------------------------------------------------------
  // Ports
  // ------------------------------------------------------------
  logic [6:0] pa_data, pa_ddr, pa_sync, pa_rd;
  logic [7:0] pb_data, pb_ddr, pb_sync, pb_rd;
  logic [7:0] pc_data, pc_ddr, pc_sync, pc_rd;

  // Port A has seven lines
  lip_port #(.W(7)) u_pa (.mclk_i(mclk_i), .rst_i(rst_all), .wr_data_i(wr_en && cpu_req_i.addr == `LIP_ADDR_PORTA),
    .wr_ddr_i(wr_en && cpu_req_i.addr == `LIP_ADDR_DDRA), .wdata_i(cpu_req_i.wdata[6:0]), .pin_i(pa_pin_i),
    .data_o(pa_data), .ddr_o(pa_ddr), .pin_sync_o(pa_sync), .rd_o(pa_rd));
  lip_port #(.W(8)) u_pb (.mclk_i(mclk_i), .rst_i(rst_all), .wr_data_i(wr_en && cpu_req_i.addr == `LIP_ADDR_PORTB),
    .wr_ddr_i(wr_en && cpu_req_i.addr == `LIP_ADDR_DDRB), .wdata_i(cpu_req_i.wdata), .pin_i(pb_pin_i),
    .data_o(pb_data), .ddr_o(pb_ddr), .pin_sync_o(pb_sync), .rd_o(pb_rd));
  lip_port #(.W(8)) u_pc (.mclk_i(mclk_i), .rst_i(rst_all), .wr_data_i(wr_en && cpu_req_i.addr == `LIP_ADDR_PORTC),
    .wr_ddr_i(wr_en && cpu_req_i.addr == `LIP_ADDR_DDRC), .wdata_i(cpu_req_i.wdata), .pin_i(pc_pin_i),
    .data_o(pc_data), .ddr_o(pc_ddr), .pin_sync_o(pc_sync), .rd_o(pc_rd));

  // ------------------------------------------------------------
  // Pin drive with shared functions
  // ------------------------------------------------------------
  lip_pkg::lip_drive_s pa_nxt, pb_nxt, pc_nxt;
  logic [7:0] pullup_out_nxt;

  // Peripheral functions override the port latch on their lines
  always_comb begin
    pa_nxt.dout = {1'b0, pa_data};
    pa_nxt.oe = {1'b0, pa_ddr};
    if (tone_dac_en_i) begin
      pa_nxt.dout[1] = tone_dac_out_i;
      pa_nxt.oe[1] = 1'b1;
    end
    if (timer_cap_en_i) begin
      pa_nxt.oe[2] = 1'b0;
    end
    if (timer_cmp_en_i) begin
      pa_nxt.dout[3] = timer_compare_out_i;
      pa_nxt.oe[3] = 1'b1;
    end
    pb_nxt.dout = pb_data;
    pb_nxt.oe = pb_ddr;
    pc_nxt.dout = pc_data;
    pc_nxt.oe = pc_ddr;
    pullup_out_nxt = pullup_r & ~pb_ddr;
  end

  // Registered pin drive
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      pa_drv_o <= '0;
      pb_drv_o <= '0;
      pc_drv_o <= '0;
      pb_pullup_o <= '0;
      timer_capture_in_o <= 1'b1;
    end else begin
      pa_drv_o <= pa_nxt;
      pb_drv_o <= pb_nxt;
      pc_drv_o <= pc_nxt;
      pb_pullup_o <= pullup_out_nxt;
      timer_capture_in_o <= pa_sync[2];
    end
  end

  // ------------------------------------------------------------
  // LED / interrupt pin
  // ------------------------------------------------------------
  logic irq_s; // Synchronised pin level
  logic irq_prev_r;
  logic irq_fall; // Falling edge seen at full clock rate
  logic edge_r; // Latched edge request
  logic edge_nxt;
  logic irq_nxt;
  logic led_oe_nxt;

  lip_sync2 #(.W(1), .RST_VAL(1'b1)) u_irq_sync (.mclk_i(mclk_i), .rst_i(rst_all), .d_i(led_irq_pin_i),
    .q_o(irq_s));
  assign irq_fall = irq_prev_r & ~irq_s;

  // Runs on every clock, not on op_en, to keep request latency short
  always_comb begin
    if (!ext_sel) begin
      edge_nxt = 1'b0;
    end else if (irq_fall) begin
      edge_nxt = 1'b1;
    end else if (irq_ack_i) begin
      edge_nxt = 1'b0;
    end else begin
      edge_nxt = edge_r;
    end
    irq_nxt = ext_sel & (edge_nxt | (trig_mode == lip_pkg::LIP_TRIG_EDGE_LEVEL & ~irq_s));
    led_oe_nxt = ~ext_sel & misc_r[`LIP_MISC_LED];
  end

  // Interrupt and LED registers
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      irq_prev_r <= 1'b1;
      edge_r <= 1'b0;
      irq_req_o <= 1'b0;
      led_irq_pin_oe_o <= 1'b0;
      led_irq_pin_o <= 1'b0; // Open drain: only ever sinks
    end else begin
      irq_prev_r <= irq_s;
      edge_r <= edge_nxt;
      irq_req_o <= irq_nxt;
      led_irq_pin_oe_o <= led_oe_nxt;
      led_irq_pin_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Keyboard flags
  // ------------------------------------------------------------
  logic [3:0] kb_prev_r;
  logic [3:0] kb_set; // Enabled falling edges
  logic [3:0] kbd_nxt;

  // Write one clears; a new edge in the same cycle wins
  always_comb begin
    kb_set = kb_prev_r & ~pb_sync[3:0] & kbd_en_r;
    kbd_nxt = kbd_flag_o;
    if (wr_en && cpu_req_i.addr == `LIP_ADDR_KBD_FLAG) begin
      kbd_nxt = kbd_nxt & ~cpu_req_i.wdata[3:0];
    end
    kbd_nxt = kbd_nxt | kb_set;
  end

  // Keyboard registers
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      kb_prev_r <= 4'hF;
      kbd_flag_o <= `LIP_KBD_RST;
      kbd_irq_o <= 1'b0;
    end else begin
      kb_prev_r <= pb_sync[3:0];
      kbd_flag_o <= kbd_nxt;
      kbd_irq_o <= |kbd_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [7:0] rd_val;
  logic [7:0] rdata_nxt;

  // Unmapped offsets read zero
  always_comb begin
    unique case (cpu_req_i.addr)
      `LIP_ADDR_PORTA: rd_val = {1'b0, pa_rd};
      `LIP_ADDR_PORTB: rd_val = pb_rd;
      `LIP_ADDR_PORTC: rd_val = pc_rd;
      `LIP_ADDR_DDRA: rd_val = {1'b0, pa_ddr};
      `LIP_ADDR_DDRB: rd_val = pb_ddr;
      `LIP_ADDR_DDRC: rd_val = pc_ddr;
      `LIP_ADDR_PULLUP: rd_val = pullup_r;
      `LIP_ADDR_KBD_EN: rd_val = {4'h0, kbd_en_r};
      `LIP_ADDR_KBD_FLAG: rd_val = {4'h0, kbd_flag_o};
      `LIP_ADDR_MISC: rd_val = misc_r;
      default: rd_val = 8'h00;
    endcase
    rdata_nxt = (op_en & cpu_req_i.rd) ? rd_val : cpu_rdata_o;
  end

  // Read data and enable out
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      cpu_rdata_o <= 8'h00;
      op_en_o <= 1'b0;
    end else begin
      cpu_rdata_o <= rdata_nxt;
      op_en_o <= op_cnt_nxt == 1'(`LIP_OSC_DIV - 1);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_all);

  a_op_divide: assert property (op_en |=> !op_en ##1 op_en)
    else $error("Operating enable not every second clock");
  a_misc_write: assert property (wr_en && cpu_req_i.addr == `LIP_ADDR_MISC |=>
    ext_sel == $past(cpu_req_i.wdata[`LIP_MISC_EXT_SEL]))
    else $error("Select bit not written at 1C");
  a_led_sink: assert property (!ext_sel && misc_r[`LIP_MISC_LED] |=> led_irq_pin_oe_o)
    else $error("LED bit set but pin not pulled low");
  a_led_mode_only: assert property (ext_sel |=> !led_irq_pin_oe_o)
    else $error("Pin driven while in interrupt mode");
  a_no_led_irq: assert property (!ext_sel ##1 !ext_sel |-> !irq_req_o)
    else $error("Interrupt raised in LED mode");
  a_irq_edge_fast: assert property (ext_sel && irq_fall |=> irq_req_o)
    else $error("Falling edge not raised next clock");
  a_irq_level: assert property (ext_sel && trig_mode == lip_pkg::LIP_TRIG_EDGE_LEVEL && !irq_s |=> irq_req_o)
    else $error("Low level not raising request");
  a_irq_edge_only: assert property (ext_sel && trig_mode == lip_pkg::LIP_TRIG_EDGE && irq_ack_i && !irq_fall
    |=> !irq_req_o)
    else $error("Edge-only request held after acknowledge");
  a_ports_input: assert property (disable iff (1'b0) rst_all |=> pb_drv_o.oe == 8'h00 && pc_drv_o.oe == 8'h00)
    else $error("Port line driven after reset");
  a_kbd_flag_set: assert property (kb_set[0] |=> kbd_flag_o[0] && kbd_irq_o)
    else $error("Key edge did not set flag");
  a_pullup_input: assert property (1'b1 |=> (pb_pullup_o & $past(pb_ddr)) == 8'h00)
    else $error("Pull-up on an output line");
  a_tone_share: assert property (tone_dac_en_i |=> pa_drv_o.oe[1] && pa_drv_o.dout[1] == $past(tone_dac_out_i))
    else $error("Tone output not on PA1");

  c_led_on: cover property (!ext_sel && misc_r[`LIP_MISC_LED] ##1 led_irq_pin_oe_o);
  c_irq_raise: cover property (ext_sel && irq_fall ##1 irq_req_o ##[0:4] irq_ack_i);
  c_kbd_clear: cover property (kbd_flag_o[0] ##[1:8] !kbd_flag_o[0]);

endmodule

// ---- rtl/lip_map.svh ----
// Register offsets, field positions, reset values and clock ratio of the pin-function block
`ifndef LIP_MAP_SVH
`define LIP_MAP_SVH

// ------------------------------------------------------------
// Register offsets in the I/O page
// ------------------------------------------------------------
`define LIP_ADDR_PORTA 5'h00
`define LIP_ADDR_PORTB 5'h01
`define LIP_ADDR_PORTC 5'h02
`define LIP_ADDR_DDRA 5'h05
`define LIP_ADDR_DDRB 5'h06
`define LIP_ADDR_DDRC 5'h07
`define LIP_ADDR_PULLUP 5'h0A
`define LIP_ADDR_KBD_EN 5'h0B
`define LIP_ADDR_KBD_FLAG 5'h0C
`define LIP_ADDR_MISC 5'h1C

// ------------------------------------------------------------
// Fields of misc_ctrl_reg
// ------------------------------------------------------------
`define LIP_MISC_EXT_SEL 7
`define LIP_MISC_TRIG 6
`define LIP_MISC_LED 5
`define LIP_MISC_WMASK 8'hE0
`define LIP_MISC_RST 8'h80

// ------------------------------------------------------------
// Reset values and clock ratio
// ------------------------------------------------------------
`define LIP_DDR_RST 8'h00
`define LIP_DATA_RST 8'h00
`define LIP_PULLUP_RST 8'h00
`define LIP_KBD_RST 4'h0
`define LIP_OSC_DIV 2
`define LIP_KBD_LINES 4

`endif

// ---- rtl/lip_pkg.sv ----
// Types shared by the pin-function block
package lip_pkg;

  // Interrupt trigger choice
  typedef enum logic {
    LIP_TRIG_EDGE,
    LIP_TRIG_EDGE_LEVEL
  } lip_trig_e;

  // One register access from the CPU
  typedef struct packed {
    logic [4:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } lip_cpu_req_s;

  // Drive of one 8-line port: level and output enable
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } lip_drive_s;

endpackage

// ---- rtl/lip_sync2.sv ----
// Two-flop synchroniser for pin levels
`timescale 1ns/100ps
module lip_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r; // First stage, read only by q_o

  // Pins idle high, so reset to the idle level to avoid false edges
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

// ---- rtl/lip_port.sv ----
// One general-purpose port: data latch, direction register and synchronised pins
`timescale 1ns/100ps
module lip_port #(
  parameter int W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wr_data_i,
  input wire logic wr_ddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] data_o,
  output logic [W-1:0] ddr_o,
  output logic [W-1:0] pin_sync_o,
  output logic [W-1:0] rd_o
);

  logic [W-1:0] data_nxt; // Next output latch
  logic [W-1:0] ddr_nxt; // Next direction

  // Pins come from outside the clock domain
  lip_sync2 #(.W(W), .RST_VAL('1)) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(pin_i),
    .q_o(pin_sync_o)
  );

  // Next values of latch and direction
  always_comb begin
    data_nxt = wr_data_i ? wdata_i : data_o;
    ddr_nxt = wr_ddr_i ? wdata_i : ddr_o;
  end

  // Every line comes up as an input
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      data_o <= W'(`LIP_DATA_RST);
      ddr_o <= W'(`LIP_DDR_RST);
    end else begin
      data_o <= data_nxt;
      ddr_o <= ddr_nxt;
    end
  end

  // Outputs read back the latch, inputs read the pin
  assign rd_o = (ddr_o & data_o) | (~ddr_o & pin_sync_o);

endmodule

// ---- sim/lip_pins_model.sv ----
// Far-side model: LED/interrupt line with its resistor to supply, and the three port pin banks
`timescale 1ns/100ps
module lip_pins_model (
  input wire logic mclk_i,
  input wire logic led_oe_i,
  input wire logic irq_src_low_i,
  input wire lip_pkg::lip_drive_s pa_drv_i,
  input wire lip_pkg::lip_drive_s pb_drv_i,
  input wire lip_pkg::lip_drive_s pc_drv_i,
  input wire logic [7:0] pb_pullup_i,
  input wire logic [23:0] ext_en_i,
  input wire logic [23:0] ext_val_i,
  output logic led_irq_pin_o,
  output logic [6:0] pa_pin_o,
  output logic [7:0] pb_pin_o,
  output logic [7:0] pc_pin_o
);
  // ------------------------------------------------------------
  // Line resolution
  // ------------------------------------------------------------
  logic [7:0] float_r; // Changing pattern so a floating line never looks stable

  initial float_r = 8'h5A;

  // Floating lines flip every cycle
  always @(posedge mclk_i) float_r <= ~float_r;

  // Wired-OR line: low when the device sinks or the source pulls low
  assign led_irq_pin_o = ~(led_oe_i | irq_src_low_i);

  // Device drive wins, then the outside driver, then pull-up, else floating
  function automatic logic [7:0] lvl(input lip_pkg::lip_drive_s d, input logic [7:0] en,
                                     input logic [7:0] v, input logic [7:0] pu);
    return (d.oe & d.dout) | (~d.oe & en & v) | (~d.oe & ~en & pu) | (~d.oe & ~en & ~pu & float_r);
  endfunction

  assign pa_pin_o = 7'(lvl(pa_drv_i, ext_en_i[7:0], ext_val_i[7:0], 8'h00));
  assign pb_pin_o = lvl(pb_drv_i, ext_en_i[15:8], ext_val_i[15:8], pb_pullup_i);
  assign pc_pin_o = lvl(pc_drv_i, ext_en_i[23:16], ext_val_i[23:16], 8'h00);
endmodule

// ---- sim/led_irq_pin_and_port_function_select_bench.sv ----
// Self-checking bench of the pin-function block against a register model
`timescale 1ns/100ps
`include "lip_map.svh"
module led_irq_pin_and_port_function_select_bench;
  // ------------------------------------------------------------
  // Stimulus, observation and model state
  // ------------------------------------------------------------
  logic mclk_i, rst_i, rst_pin_n, irq_ack, irq_src_low, led_pin, led_oe, irq_req, op_en, led_lvl;
  logic tone_en, tone_out, cap_en, cmp_en, cmp_out, kbd_irq, cap_in;
  logic [23:0] ext_en, ext_val;
  logic [7:0] rdata, pb_pu, pb_pin, pc_pin, dd, dt, pu, ev, mk;
  logic [6:0] pa_pin;
  logic [3:0] kflag;
  lip_pkg::lip_cpu_req_s req;
  lip_pkg::lip_drive_s pa_drv, pb_drv, pc_drv, d;
  int m [32]; // Model of register contents
  int err_count, checks_done, n;
  logic [4:0] ctl_a [8] = '{`LIP_ADDR_DDRA, `LIP_ADDR_DDRB, `LIP_ADDR_DDRC, `LIP_ADDR_PULLUP,
                            `LIP_ADDR_KBD_EN, `LIP_ADDR_MISC, 5'h03, 5'h10};

  lip_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .reset_pin_n_i(rst_pin_n), .cpu_req_i(req),
    .cpu_rdata_o(rdata), .op_en_o(op_en), .irq_ack_i(irq_ack), .irq_req_o(irq_req),
    .led_irq_pin_i(led_pin), .led_irq_pin_o(led_lvl), .led_irq_pin_oe_o(led_oe), .pa_pin_i(pa_pin),
    .pb_pin_i(pb_pin), .pc_pin_i(pc_pin), .pa_drv_o(pa_drv), .pb_drv_o(pb_drv), .pc_drv_o(pc_drv),
    .pb_pullup_o(pb_pu), .kbd_flag_o(kflag), .kbd_irq_o(kbd_irq), .tone_dac_en_i(tone_en),
    .tone_dac_out_i(tone_out), .timer_cap_en_i(cap_en), .timer_capture_in_o(cap_in),
    .timer_cmp_en_i(cmp_en), .timer_compare_out_i(cmp_out));

  lip_pins_model pins (.mclk_i(mclk_i), .led_oe_i(led_oe), .irq_src_low_i(irq_src_low),
    .pa_drv_i(pa_drv), .pb_drv_i(pb_drv), .pc_drv_i(pc_drv), .pb_pullup_i(pb_pu),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .led_irq_pin_o(led_pin), .pa_pin_o(pa_pin),
    .pb_pin_o(pb_pin), .pc_pin_o(pc_pin));

  // Oscillator clock, 10 ns
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Inputs always move 1 ns after the edge
  task automatic tick(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask

  // Waits until the operating enable is high, then drives the request for one edge
  task automatic cpu_acc(input logic [4:0] a, input logic w, input logic [7:0] v);
    while (op_en !== 1'b1) tick(1);
    req = '{addr: a, wr: w, rd: ~w, wdata: v};
    tick(1);
    req = '0;
  endtask

  // Write, then mirror the writable bits in the model
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    cpu_acc(a, 1'b1, v);
    case (a)
      `LIP_ADDR_PORTA, `LIP_ADDR_DDRA: m[a] = v & 8'h7F;
      `LIP_ADDR_PORTB, `LIP_ADDR_PORTC, `LIP_ADDR_DDRB, `LIP_ADDR_DDRC, `LIP_ADDR_PULLUP: m[a] = v;
      `LIP_ADDR_KBD_EN: m[a] = v & 8'h0F;
      `LIP_ADDR_MISC: m[a] = v & `LIP_MISC_WMASK;
      default: ;
    endcase
  endtask

  task automatic rd(input logic [4:0] a, input string nm, input logic [7:0] e);
    cpu_acc(a, 1'b0, 8'h00);
    tick(1);
    chk(nm, rdata, e);
  endtask

  task automatic reset_model();
    m = '{default: 0};
    m[`LIP_ADDR_MISC] = `LIP_MISC_RST;
  endtask

  // Start-up state of every control register and drive
  task automatic reset_checks();
    foreach (ctl_a[i]) rd(ctl_a[i], "reset reg", m[ctl_a[i]][7:0]);
    chk("port oe", pa_drv.oe | pb_drv.oe | pc_drv.oe, 8'h00);
    chk("idle outs", pb_pu | {7'h00, led_oe | led_lvl}, 8'h00);
  endtask

  task automatic wait_irq();
    n = 0;
    while (irq_req !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk("irq raised", 8'(irq_req), 8'h01);
  endtask

  task automatic pulse_ack();
    irq_ack = 1'b1;
    tick(1);
    irq_ack = 1'b0;
    tick(2);
  endtask

  // Hang guard: the run needs well under 5 us
  initial begin
    #50us;
    err_count++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_i, rst_pin_n, ext_en} = {2'b11, 24'hFFFFFF};
    {irq_ack, irq_src_low, tone_en, tone_out, cap_en, cmp_en, cmp_out} = '0;
    {req, ext_val, err_count, checks_done} = '0;
    void'($urandom(32'h9CF15ABE));
    reset_model();
    tick(12);
    rst_i = 1'b0;
    n = 0;
    repeat (8) begin
      tick(1);
      n += int'(op_en === 1'b1);
    end
    chk("op rate", 8'(n), 8'h04);
    wr(5'h03, 8'hFF);
    reset_checks();
    // Random direction and data on every port, random pull-ups on port B
    for (int p = 0; p < 3; p++) begin
      repeat (3) begin
        {dd, dt, pu, ev} = $urandom;
        mk = (p == 0) ? 8'h7F : 8'hFF;
        ext_val[8*p +: 8] = ev;
        wr(5'(`LIP_ADDR_DDRA + p), dd);
        wr(5'(p), dt);
        wr(`LIP_ADDR_PULLUP, pu);
        tick(4);
        d = (p == 0) ? pa_drv : (p == 1) ? pb_drv : pc_drv;
        chk("oe", d.oe, dd & mk);
        chk("dout", d.dout & dd & mk, dt & dd & mk);
        chk("pull-up", pb_pu, pu & ~m[`LIP_ADDR_DDRB][7:0]);
        rd(5'(p), "port read", ((dt & dd) | (ev & ~dd)) & mk);
      end
      wr(5'(`LIP_ADDR_DDRA + p), 8'h00);
    end
    // Shared functions override the latch, PA2 forced to input
    wr(`LIP_ADDR_DDRA, 8'h04);
    {tone_en, cap_en, cmp_en} = 3'b111;
    for (int k = 0; k < 2; k++) begin
      {tone_out, cmp_out, ext_val[2]} = {k[0], ~k[0], k[0]};
      tick(5);
      chk("tone", 8'({pa_drv.oe[1], pa_drv.dout[1]}), 8'({1'b1, k[0]}));
      chk("capture", 8'({pa_drv.oe[2], cap_in}), 8'({1'b0, k[0]}));
      chk("compare", 8'({pa_drv.oe[3], pa_drv.dout[3]}), 8'({1'b1, ~k[0]}));
    end
    {tone_en, cap_en, cmp_en} = 3'b000;
    // Keyboard flags: only enabled lines, write one to clear
    ext_val[15:8] = 8'hFF;
    wr(`LIP_ADDR_KBD_EN, 8'h05);
    tick(4);
    ext_val[11:8] = 4'h0;
    tick(6);
    chk("key flags", {kbd_irq, 3'b000, kflag}, 8'h85);
    rd(`LIP_ADDR_KBD_FLAG, "key read", 8'h05);
    wr(`LIP_ADDR_KBD_FLAG, 8'h01);
    tick(2);
    chk("key clear", 8'(kflag), 8'h04);
    wr(`LIP_ADDR_KBD_FLAG, 8'h04);
    tick(3);
    chk("key idle", {kbd_irq, 3'b000, kflag}, 8'h00);
    ext_val[11:8] = 4'hF;
    // Edge-only trigger: ack clears though the line stays low; edge-plus-level holds the request until the line rises
    irq_src_low = 1'b1;
    wait_irq();
    pulse_ack();
    chk("edge ack", 8'(irq_req), 8'h00);
    irq_src_low = 1'b0;
    wr(`LIP_ADDR_MISC, 8'hC0);
    irq_src_low = 1'b1;
    wait_irq();
    pulse_ack();
    chk("level held", 8'(irq_req), 8'h01);
    irq_src_low = 1'b0;
    tick(4);
    pulse_ack();
    chk("level ack", 8'(irq_req), 8'h00);
    // LED function and its select bit
    wr(`LIP_ADDR_MISC, 8'hFF);
    tick(3);
    rd(`LIP_ADDR_MISC, "misc read", m[`LIP_ADDR_MISC][7:0]);
    chk("irq mode led", 8'(led_oe), 8'h00);
    wr(`LIP_ADDR_MISC, 8'h20);
    tick(3);
    chk("led on", 8'({led_lvl, led_oe}), 8'h01);
    irq_src_low = 1'b1;
    tick(8);
    chk("no irq led", 8'(irq_req), 8'h00);
    wr(`LIP_ADDR_MISC, 8'h00);
    tick(3);
    chk("led off", 8'(led_oe), 8'h00);
    irq_src_low = 1'b0;
    tick(4);
    irq_src_low = 1'b1;
    tick(8);
    chk("no irq edge", 8'(irq_req), 8'h00);
    irq_src_low = 1'b0;
    // Reset pin in mid-run
    wr(`LIP_ADDR_DDRB, 8'hFF);
    rst_pin_n = 1'b0;
    tick(5);
    reset_model();
    chk("pin reset oe", pb_drv.oe, 8'h00);
    rst_pin_n = 1'b1;
    tick(4);
    reset_checks();
    finish_test();
  end
endmodule
